// ### sdio_ctrl_model.sv
// controller-side model that drives the block's discrete pins
`timescale 1ns/1ps
module sdio_ctrl_model (
  input wire logic mclk,
  input wire logic [sdio_pkg::N_IN-1:0] req,
  output logic enable_in_b,
  output logic direction_in_b,
  output logic brake_in_b,
  output logic limit_fwd_in_b,
  output logic limit_rev_in_b,
  output logic capture_in_b,
  output logic step_in
);
  // pin levels, all released high until asked otherwise
  logic [sdio_pkg::N_IN-1:0] lvl = 7'h7f;
  // levels move only just after a rising edge, like a plc output
  always @(posedge mclk) begin
    lvl <= req;
  end
  // held low to run, taken high then low to re-arm
  assign enable_in_b = lvl[sdio_pkg::IN_EN];
  assign direction_in_b = lvl[sdio_pkg::IN_DIR];
  assign brake_in_b = lvl[sdio_pkg::IN_BRK];
  assign limit_fwd_in_b = lvl[sdio_pkg::IN_LFWD];
  assign limit_rev_in_b = lvl[sdio_pkg::IN_LREV];
  // open collector: released means the pull-up wins
  assign capture_in_b = lvl[sdio_pkg::IN_CAP];
  assign step_in = lvl[sdio_pkg::IN_STEP];
endmodule

// ### sdio_edge.sv
// edge detector on a synchronised level
`timescale 1ns/1ps
module sdio_edge #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic d,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic last;
  } sdio_edge_s;
  sdio_edge_s st_reg;
  sdio_edge_s st_next;
  // remember the previous level
  always_comb begin
    st_next.last = d;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= RST_VAL;
    end else begin
      st_reg <= st_next;
    end
  end
  assign rise = d & ~st_reg.last;
  assign fall = ~d & st_reg.last;
endmodule

// ### sdio_pkg.sv
// package of register map, field positions and widths for the servo i/o block
package sdio_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int POS_W = 32;
  localparam int CMD_W = 16;
  // register word indices; byte address is index times four
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IGNORE = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PRESET = 4'h3;
  localparam logic [ADDR_W-1:0] REG_FIXED_CMD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CAP_POS = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STEP_POS = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STEP_INC = 4'h7;
  localparam logic [ADDR_W-1:0] REG_CAN_CMD = 4'h8;
  localparam logic [ADDR_W-1:0] REG_CAP_CNT = 4'h9;
  // ctrl bits
  localparam int CTRL_NOIO = 0;
  localparam int CTRL_FIXDIR = 1;
  localparam int CTRL_CANSEL = 2;
  localparam int CTRL_FAULT_SET = 3;
  localparam int CTRL_FAULT_CLR = 4;
  localparam int CTRL_BRAKE_REL = 5;
  // input index in ignore and preset masks
  localparam int IN_EN = 0;
  localparam int IN_DIR = 1;
  localparam int IN_BRK = 2;
  localparam int IN_LFWD = 3;
  localparam int IN_LREV = 4;
  localparam int IN_CAP = 5;
  localparam int IN_STEP = 6;
  localparam int N_IN = 7;
  // status bits
  localparam int ST_RUN = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_ARMED = 2;
  localparam int ST_PIN0 = 8;
  localparam logic [N_IN-1:0] PRESET_RST = 7'h7f;
  localparam logic [DATA_W-1:0] STEP_INC_RST = 32'h00000001;
  localparam logic [DATA_W-1:0] BAD_DATA = 32'hdeadbeef;
endpackage

// ### sdio_sync.sv
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
module sdio_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sdio_sync_s;
  sdio_sync_s st_reg;
  sdio_sync_s st_next;
  // first stage feeds only the second
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end
  // idle level on reset matches the pull-up
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= {RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end
  assign q = st_reg.s2;
endmodule

// ### sdio_top.sv
// servo drive discrete i/o control with avalon-mm register slave
// What this block does
// - direction low inverts the motor command, except in no-i/o mode
// - falling edge on capture is one trigger
// - trigger snapshots the running encoder count
// - captured count held and readable by host
// - fault output pulled low while faulted
// - ready output pulled low while ready
// - drive runs only while enable held low, except in no-i/o mode
// - after fault, enable must go high-low again, except in no-i/o mode
// - brake input low applies dynamic braking
// - forward limit low blocks positive current
// - reverse limit low blocks negative current
// - each input may be ignored, preset used
// - no-i/o mode ignores enable, fixed command
// - each step while running adds encoder res over steps, subtracts it with direction low
// - step and direction states readable by host
// - network commands accepted with or without i/o
// - open-drain output engages holding brake
// - undriven capture reads high, inactive
// - rising step edge counts one step while running
`timescale 1ns/1ps
module sdio_top #(
  parameter int CMD_W = sdio_pkg::CMD_W,
  parameter int POS_W = sdio_pkg::POS_W
) (
  input wire logic mclk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [sdio_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [sdio_pkg::DATA_W-1:0] avs_writedata,
  output logic [sdio_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // discrete pins, all active low except step_in, which counts rising edges
  input wire logic enable_in_b,
  input wire logic direction_in_b,
  input wire logic brake_in_b,
  input wire logic limit_fwd_in_b,
  input wire logic limit_rev_in_b,
  input wire logic capture_in_b,
  input wire logic step_in,
  // drive core side
  input wire logic [POS_W-1:0] encoder_count,
  input wire logic drive_fault,
  input wire logic signed [CMD_W-1:0] analog_cmd,
  output logic signed [CMD_W-1:0] motor_cmd,
  output logic drive_run,
  output logic dyn_brake,
  output logic pos_current_inhibit,
  output logic neg_current_inhibit,
  output logic [POS_W-1:0] step_target,
  // open-drain outputs: out is always 0, oe pulls the pin low
  output logic fault_out,
  output logic fault_oe,
  output logic ready_out,
  output logic ready_oe,
  output logic holding_brake_out,
  output logic holding_brake_oe
);
  ////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  logic rst_q1;
  logic rst_sync_b; // released copy of reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1 <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_sync_b <= rst_q1;
    end
  end

  logic [sdio_pkg::N_IN-1:0] pin_raw; // pins in mask order
  logic [sdio_pkg::N_IN-1:0] pin_sync; // synchronised pins
  logic [sdio_pkg::N_IN-1:0] pin_eff; // after ignore/preset
  logic [sdio_pkg::N_IN-1:0] pin_rise;
  logic [sdio_pkg::N_IN-1:0] pin_fall;
  logic [sdio_pkg::N_IN-1:0] ignore_mask;
  logic [sdio_pkg::N_IN-1:0] preset_val;

  always_comb begin
    pin_raw = '0;
    pin_raw[sdio_pkg::IN_EN] = enable_in_b;
    pin_raw[sdio_pkg::IN_DIR] = direction_in_b;
    pin_raw[sdio_pkg::IN_BRK] = brake_in_b;
    pin_raw[sdio_pkg::IN_LFWD] = limit_fwd_in_b;
    pin_raw[sdio_pkg::IN_LREV] = limit_rev_in_b;
    pin_raw[sdio_pkg::IN_CAP] = capture_in_b;
    pin_raw[sdio_pkg::IN_STEP] = step_in;
  end

  // idle high on reset mirrors the pull-ups, so nothing fires at start
  genvar gi;
  generate
    for (gi = 0; gi < sdio_pkg::N_IN; gi++) begin : g_in
      sdio_sync #(.RST_VAL(1'b1)) u_sync (
        .mclk(mclk),
        .rst_b(rst_sync_b),
        .d(pin_raw[gi]),
        .q(pin_sync[gi])
      );
      // ignored inputs take the preset level instead of the pin
      assign pin_eff[gi] = ignore_mask[gi] ? preset_val[gi]
                                           : pin_sync[gi];
      sdio_edge #(.RST_VAL(1'b1)) u_edge (
        .mclk(mclk),
        .rst_b(rst_sync_b),
        .d(pin_eff[gi]),
        .rise(pin_rise[gi]),
        .fall(pin_fall[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {
    SDIO_WAIT_HIGH, // must see enable released first
    SDIO_ARMED,     // high seen, waiting for the low edge
    SDIO_RUN,
    SDIO_FAULT
  } sdio_en_e;

  typedef struct packed {
    sdio_en_e en_st;
    logic noio;
    logic fixdir;
    logic can_sel;
    logic brake_rel;
    logic sw_fault;
    logic [sdio_pkg::N_IN-1:0] ignore;
    logic [sdio_pkg::N_IN-1:0] preset;
    logic [sdio_pkg::DATA_W-1:0] fixed_cmd;
    logic [sdio_pkg::DATA_W-1:0] can_cmd;
    logic [POS_W-1:0] cap_pos;
    logic [sdio_pkg::DATA_W-1:0] cap_cnt;
    logic [POS_W-1:0] step_pos;
    logic [POS_W-1:0] step_inc;
    logic signed [CMD_W-1:0] cmd_q;
    logic fault_q;
    logic ready_q;
    logic brake_q;
    logic [sdio_pkg::DATA_W-1:0] rdata;
    logic ack;
  } sdio_s;

  sdio_s st_reg;
  sdio_s st_next;

  assign ignore_mask = st_reg.ignore;
  assign preset_val = st_reg.preset;

  logic faulted; // any fault source
  logic en_low; // effective enable asserted
  logic en_rise; // enable released
  logic en_fall; // enable asserted edge
  logic signed [CMD_W-1:0] base_cmd;
  logic signed [CMD_W-1:0] dir_cmd;
  logic reverse;
  logic access; // a bus request is pending
  logic [sdio_pkg::DATA_W-1:0] rd_mux;

  assign faulted = drive_fault | st_reg.sw_fault;
  assign en_low = ~pin_eff[sdio_pkg::IN_EN];
  assign en_rise = pin_rise[sdio_pkg::IN_EN];
  assign en_fall = pin_fall[sdio_pkg::IN_EN];
  assign access = (avs_read | avs_write) & ~st_reg.ack;

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_mux = sdio_pkg::BAD_DATA; // unmapped answer
    case (avs_address)
      sdio_pkg::REG_CTRL: begin
        rd_mux = '0;
        rd_mux[sdio_pkg::CTRL_NOIO] = st_reg.noio;
        rd_mux[sdio_pkg::CTRL_FIXDIR] = st_reg.fixdir;
        rd_mux[sdio_pkg::CTRL_CANSEL] = st_reg.can_sel;
        rd_mux[sdio_pkg::CTRL_FAULT_SET] = st_reg.sw_fault;
        rd_mux[sdio_pkg::CTRL_BRAKE_REL] = st_reg.brake_rel;
      end
      sdio_pkg::REG_STATUS: begin
        rd_mux = '0;
        rd_mux[sdio_pkg::ST_RUN] = (st_reg.en_st == SDIO_RUN);
        rd_mux[sdio_pkg::ST_FAULT] = (st_reg.en_st == SDIO_FAULT);
        rd_mux[sdio_pkg::ST_ARMED] = (st_reg.en_st == SDIO_ARMED);
        // live pin levels, step and direction among them
        rd_mux[sdio_pkg::ST_PIN0 +: sdio_pkg::N_IN] = pin_sync;
      end
      // narrow masks sit in the low bits, the rest reads zero
      sdio_pkg::REG_IGNORE: begin
        rd_mux = '0;
        rd_mux[sdio_pkg::N_IN-1:0] = st_reg.ignore;
      end
      sdio_pkg::REG_PRESET: begin
        rd_mux = '0;
        rd_mux[sdio_pkg::N_IN-1:0] = st_reg.preset;
      end
      sdio_pkg::REG_FIXED_CMD: rd_mux = st_reg.fixed_cmd;
      sdio_pkg::REG_CAP_POS: rd_mux = st_reg.cap_pos;
      sdio_pkg::REG_STEP_POS: rd_mux = st_reg.step_pos;
      sdio_pkg::REG_STEP_INC: rd_mux = st_reg.step_inc;
      sdio_pkg::REG_CAN_CMD: rd_mux = st_reg.can_cmd;
      sdio_pkg::REG_CAP_CNT: rd_mux = st_reg.cap_cnt;
      default: rd_mux = sdio_pkg::BAD_DATA;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // command path
  always_comb begin
    // network command overrides pin/analog source, usable either way
    if (st_reg.can_sel) begin
      base_cmd = st_reg.can_cmd[CMD_W-1:0];
    end else if (st_reg.noio) begin
      base_cmd = st_reg.fixed_cmd[CMD_W-1:0];
    end else begin
      base_cmd = analog_cmd;
    end
    // fixed direction replaces the pin in no-i/o mode
    reverse = st_reg.noio ? st_reg.fixdir
                          : ~pin_eff[sdio_pkg::IN_DIR];
    dir_cmd = reverse ? -base_cmd : base_cmd;
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;

    // enable sequencing; fault forces a fresh high-low toggle, except in no-i/o mode
    case (st_reg.en_st)
      SDIO_WAIT_HIGH: begin
        if (!en_low) begin
          st_next.en_st = SDIO_ARMED;
        end
      end
      SDIO_ARMED: begin
        if (en_fall) begin
          st_next.en_st = SDIO_RUN;
        end
      end
      SDIO_RUN: begin
        if (!en_low && !st_reg.noio) begin
          st_next.en_st = SDIO_ARMED;
        end
      end
      SDIO_FAULT: begin
        if (!faulted) begin
          st_next.en_st = SDIO_WAIT_HIGH;
        end
      end
      default: st_next.en_st = SDIO_WAIT_HIGH;
    endcase
    // no-i/o mode runs without the enable pin
    if (st_reg.noio && st_next.en_st != SDIO_FAULT &&
        st_reg.en_st != SDIO_FAULT) begin
      st_next.en_st = SDIO_RUN;
    end
    if (faulted) begin
      st_next.en_st = SDIO_FAULT;
    end

    // capture snapshot on falling edge
    if (pin_fall[sdio_pkg::IN_CAP]) begin
      st_next.cap_pos = encoder_count;
      st_next.cap_cnt = st_reg.cap_cnt + 1'b1;
    end

    // step scaling; increment is encoder res / steps per rev
    if (pin_rise[sdio_pkg::IN_STEP] && st_reg.en_st == SDIO_RUN) begin
      if (pin_eff[sdio_pkg::IN_DIR]) begin
        st_next.step_pos = st_reg.step_pos + st_reg.step_inc;
      end else begin
        st_next.step_pos = st_reg.step_pos - st_reg.step_inc;
      end
    end

    // registered outputs
    st_next.cmd_q = (st_reg.en_st == SDIO_RUN) ? dir_cmd : '0;
    st_next.fault_q = (st_reg.en_st == SDIO_FAULT);
    // ready only while not faulted keeps both pins apart
    st_next.ready_q = (st_reg.en_st != SDIO_FAULT) &&
                      (st_reg.en_st == SDIO_RUN);
    // hold brake engaged unless running and released by software
    st_next.brake_q = !(st_reg.en_st == SDIO_RUN && st_reg.brake_rel);

    // bus slave: one wait cycle, then ack
    if (access) begin
      st_next.ack = 1'b1;
      st_next.rdata = rd_mux;
      if (avs_write) begin
        case (avs_address)
          sdio_pkg::REG_CTRL: begin
            st_next.noio = avs_writedata[sdio_pkg::CTRL_NOIO];
            st_next.fixdir = avs_writedata[sdio_pkg::CTRL_FIXDIR];
            st_next.can_sel = avs_writedata[sdio_pkg::CTRL_CANSEL];
            st_next.brake_rel = avs_writedata[sdio_pkg::CTRL_BRAKE_REL];
            if (avs_writedata[sdio_pkg::CTRL_FAULT_SET]) begin
              st_next.sw_fault = 1'b1;
            end else if (avs_writedata[sdio_pkg::CTRL_FAULT_CLR]) begin
              st_next.sw_fault = 1'b0;
            end
          end
          sdio_pkg::REG_IGNORE: begin
            st_next.ignore = avs_writedata[sdio_pkg::N_IN-1:0];
          end
          sdio_pkg::REG_PRESET: begin
            st_next.preset = avs_writedata[sdio_pkg::N_IN-1:0];
          end
          sdio_pkg::REG_FIXED_CMD: st_next.fixed_cmd = avs_writedata;
          sdio_pkg::REG_STEP_POS: st_next.step_pos = avs_writedata;
          sdio_pkg::REG_STEP_INC: st_next.step_inc = avs_writedata;
          sdio_pkg::REG_CAN_CMD: st_next.can_cmd = avs_writedata;
          default: st_next.ack = 1'b1; // writes elsewhere dropped
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_reg <= '0;
      st_reg.en_st <= SDIO_WAIT_HIGH;
      st_reg.preset <= sdio_pkg::PRESET_RST;
      st_reg.step_inc <= sdio_pkg::STEP_INC_RST;
      st_reg.brake_q <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
  assign avs_readdata = st_reg.rdata;
  assign motor_cmd = st_reg.cmd_q;
  assign drive_run = (st_reg.en_st == SDIO_RUN);
  // dynamic braking flag from the brake pin; motor_cmd is not gated by it
  assign dyn_brake = ~pin_eff[sdio_pkg::IN_BRK];
  assign pos_current_inhibit = ~pin_eff[sdio_pkg::IN_LFWD];
  assign neg_current_inhibit = ~pin_eff[sdio_pkg::IN_LREV];
  assign step_target = st_reg.step_pos;
  assign fault_out = 1'b0;
  assign fault_oe = st_reg.fault_q;
  assign ready_out = 1'b0;
  assign ready_oe = st_reg.ready_q & ~st_reg.fault_q;
  assign holding_brake_out = 1'b0;
  assign holding_brake_oe = st_reg.brake_q;
endmodule

// ### sdio_top_checker.sv
// port-level assertion checker for the servo i/o block
`timescale 1ns/1ps
module sdio_checker #(
  parameter int CMD_W = 16,
  parameter int POS_W = 32
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic brake_in_b,
  input wire logic limit_fwd_in_b,
  input wire logic limit_rev_in_b,
  input wire logic drive_fault,
  input wire logic signed [CMD_W-1:0] motor_cmd,
  input wire logic drive_run,
  input wire logic dyn_brake,
  input wire logic pos_current_inhibit,
  input wire logic neg_current_inhibit,
  input wire logic [POS_W-1:0] step_target,
  input wire logic fault_oe,
  input wire logic ready_oe
);
  // one clock domain, all checks quiet while reset is low
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////
  // a request in its first, waiting cycle
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // the answer cycle
  sequence s_ack;
    !avs_waitrequest;
  endsequence
  property p_bus_wait;
    s_req |=> s_ack;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus answer not one cycle after request");
  property p_excl;
    !(fault_oe && ready_oe);
  endproperty
  a_excl: assert property (p_excl)
    else $error("fault and ready pulled low together");
  // a steady core fault must show and stop the drive
  property p_fault;
    drive_fault [*4] |-> fault_oe && !drive_run;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault not reported or drive still running");
  // ready registered one cycle after the run state, so a one-cycle skew is tolerated
  property p_ready;
    (ready_oe != drive_run) |=> (ready_oe == drive_run);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready output does not follow run state");
  property p_stop;
    !drive_run [*2] |-> motor_cmd == '0;
  endproperty
  a_stop: assert property (p_stop)
    else $error("command nonzero while stopped");
  property p_brake;
    !brake_in_b [*5] |-> dyn_brake;
  endproperty
  a_brake: assert property (p_brake)
    else $error("dynamic brake not applied");
  property p_fwd;
    !limit_fwd_in_b [*5] |-> pos_current_inhibit;
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("positive current not inhibited");
  property p_rev;
    !limit_rev_in_b [*5] |-> neg_current_inhibit;
  endproperty
  a_rev: assert property (p_rev)
    else $error("negative current not inhibited");
  // no steps may count while stopped and software is silent
  property p_step;
    (!drive_run && !avs_write) [*3] |-> $stable(step_target);
  endproperty
  a_step: assert property (p_step)
    else $error("step position moved while stopped");
endmodule

bind sdio_top sdio_checker #(.CMD_W(CMD_W), .POS_W(POS_W)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .brake_in_b(brake_in_b),
  .limit_fwd_in_b(limit_fwd_in_b), .limit_rev_in_b(limit_rev_in_b),
  .drive_fault(drive_fault), .motor_cmd(motor_cmd), .drive_run(drive_run),
  .dyn_brake(dyn_brake), .pos_current_inhibit(pos_current_inhibit),
  .neg_current_inhibit(neg_current_inhibit), .step_target(step_target),
  .fault_oe(fault_oe), .ready_oe(ready_oe)
);

// ### test_servo_drive_io_control.sv
// self-checking bench for the servo i/o block
`timescale 1ns/1ps
module test_servo_drive_io_control;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [sdio_pkg::ADDR_W-1:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [6:0] req = 7'h7f; // wanted pin levels, high is released
  logic en_b, dir_b, brk_b, lfwd_b, lrev_b, cap_b, step;
  logic [31:0] encoder_count = 32'h0;
  logic drive_fault = 1'b0;
  logic signed [15:0] analog_cmd = 16'sh0;
  logic signed [15:0] motor_cmd;
  logic signed [15:0] v; // random fixed or network command
  logic drive_run, dyn_brake, pos_inh, neg_inh, fault_oe, ready_oe, hb_oe;
  logic [31:0] step_target;
  logic [31:0] cap_v; // count held while capture fires
  logic [63:0] notes[$]; // mask and expected read data
  integer bad_count = 0;
  integer tests_run = 0;
  integer seed = 32'h2b29;

  always #12.5 mclk = ~mclk;

  sdio_top dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .enable_in_b(en_b), .direction_in_b(dir_b), .brake_in_b(brk_b),
    .limit_fwd_in_b(lfwd_b), .limit_rev_in_b(lrev_b), .capture_in_b(cap_b),
    .step_in(step), .encoder_count(encoder_count), .drive_fault(drive_fault),
    .analog_cmd(analog_cmd), .motor_cmd(motor_cmd), .drive_run(drive_run),
    .dyn_brake(dyn_brake), .pos_current_inhibit(pos_inh),
    .neg_current_inhibit(neg_inh), .step_target(step_target),
    .fault_out(), .fault_oe(fault_oe), .ready_out(), .ready_oe(ready_oe),
    .holding_brake_out(), .holding_brake_oe(hb_oe));

  sdio_ctrl_model u_ctrl (.mclk(mclk), .req(req), .enable_in_b(en_b),
    .direction_in_b(dir_b), .brake_in_b(brk_b), .limit_fwd_in_b(lfwd_b),
    .limit_rev_in_b(lrev_b), .capture_in_b(cap_b), .step_in(step));
  //////////////////////////////////////////////////////////////////////////
  // one comparison, counted, mismatch reported at once
  task automatic check(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // read with its expectation queued for the watcher
  task automatic rd(input logic [3:0] a, input logic [31:0] m, e);
    notes.push_back({m, e & m});
    bus(1'b0, a, 32'h0);
  endtask
  // one step pulse from the idle-high pin; the rising edge counts and
  // the long tail lets the count settle before anyone looks at it
  task automatic pulse();
    req[sdio_pkg::IN_STEP] <= 1'b0;
    wt(4);
    req[sdio_pkg::IN_STEP] <= 1'b1;
    wt(6);
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watcher: read data taken at the edge that ends the wait
  always @(posedge mclk) begin
    if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
      check("readdata", avs_readdata & notes[0][63:32], notes[0][31:0]);
      void'(notes.pop_front());
    end
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    wt(20000);
    bad_count++;
    finish_test();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    wt(3);
    rst_b <= 1'b1;
    wt(4);
    check("hold_brake", 32'(hb_oe), 32'h1);
    rd(sdio_pkg::REG_STEP_INC, '1, sdio_pkg::STEP_INC_RST);
    rd(sdio_pkg::REG_PRESET, '1, 32'(sdio_pkg::PRESET_RST));
    bus(1'b1, 4'hf, 32'h5);
    rd(4'hf, '1, sdio_pkg::BAD_DATA);
    done("reset");
    analog_cmd <= {1'b0, 15'($random(seed))};
    req[sdio_pkg::IN_EN] <= 1'b0;
    wt(12);
    check("run", 32'(drive_run), 32'h1);
    check("ready", 32'(ready_oe), 32'h1);
    check("fault", 32'(fault_oe), 32'h0);
    check("cmd", 32'(motor_cmd), 32'(analog_cmd));
    req[sdio_pkg::IN_DIR] <= 1'b0;
    wt(12);
    check("cmd", 32'(motor_cmd), 32'(-analog_cmd));
    rd(sdio_pkg::REG_STATUS, 32'h7f03, 32'h7c01);
    done("run");
    // capture: count held steady around the falling edge
    cap_v = $random(seed);
    encoder_count <= cap_v;
    wt(2);
    req[sdio_pkg::IN_CAP] <= 1'b0;
    wt(8);
    encoder_count <= ~cap_v;
    req[sdio_pkg::IN_CAP] <= 1'b1;
    wt(8);
    rd(sdio_pkg::REG_CAP_POS, '1, cap_v);
    rd(sdio_pkg::REG_CAP_CNT, '1, 32'h1);
    done("capture");
    bus(1'b1, sdio_pkg::REG_STEP_INC, 32'h5);
    bus(1'b1, sdio_pkg::REG_STEP_POS, 32'h0);
    req[sdio_pkg::IN_DIR] <= 1'b1;
    repeat (3) pulse();
    req[sdio_pkg::IN_DIR] <= 1'b0;
    pulse();
    check("step", step_target, 32'd10);
    rd(sdio_pkg::REG_STEP_POS, '1, 32'd10);
    done("step");
    drive_fault <= 1'b1;
    wt(6);
    check("fault", 32'(fault_oe), 32'h1);
    drive_fault <= 1'b0;
    // software fault set, seen on the pin and in control, then cleared
    bus(1'b1, sdio_pkg::REG_CTRL, 32'h8);
    wt(6);
    check("swfault", 32'(fault_oe), 32'h1);
    rd(sdio_pkg::REG_CTRL, 32'h8, 32'h8);
    bus(1'b1, sdio_pkg::REG_CTRL, 32'h10);
    wt(12);
    check("rearm", 32'(drive_run), 32'h0);
    req[sdio_pkg::IN_EN] <= 1'b1;
    wt(8);
    req[sdio_pkg::IN_EN] <= 1'b0;
    wt(12);
    check("rearm", 32'(drive_run), 32'h1);
    // running with the brake released by software lets the pin go
    bus(1'b1, sdio_pkg::REG_CTRL, 32'h20);
    wt(4);
    check("hold_brake", 32'(hb_oe), 32'h0);
    done("fault");
    // direction pin forward, but ignored with a reverse preset
    req[sdio_pkg::IN_DIR] <= 1'b1;
    bus(1'b1, sdio_pkg::REG_PRESET, 32'h7d);
    bus(1'b1, sdio_pkg::REG_IGNORE, 32'h2);
    wt(6);
    check("ignore", 32'(motor_cmd), 32'(-analog_cmd));
    bus(1'b1, sdio_pkg::REG_IGNORE, 32'h0);
    done("ignore");
    // no-i/o mode runs with enable released, fixed reverse
    v = {1'b0, 15'($random(seed))};
    req[sdio_pkg::IN_EN] <= 1'b1;
    bus(1'b1, sdio_pkg::REG_FIXED_CMD, 32'(v));
    bus(1'b1, sdio_pkg::REG_CTRL, 32'h3);
    wt(12);
    check("noio", 32'(drive_run), 32'h1);
    check("noio", 32'(motor_cmd), 32'(-v));
    bus(1'b1, sdio_pkg::REG_CTRL, 32'h0);
    req[sdio_pkg::IN_EN] <= 1'b0;
    wt(12);
    bus(1'b1, sdio_pkg::REG_CAN_CMD, 32'(v));
    bus(1'b1, sdio_pkg::REG_CTRL, 32'h4);
    wt(6);
    check("network", 32'(motor_cmd), 32'(v));
    done("modes");
    {req[2], req[3], req[4]} <= 3'b000;
    wt(8);
    check("limits", 32'({dyn_brake, pos_inh, neg_inh}), 32'h7);
    {req[2], req[3], req[4]} <= 3'b111;
    wt(8);
    done("limits");
    finish_test();
  end
endmodule
